//--- dv/test_tws_ctrl.sv
// Purpose: self-checking bench of the serial port control block
// Assumes: 4 ns core clock, inputs change 1 ns after the rising edge
// Notes: pins resolve between device drivers and the far side
`timescale 1ns/10ps
`default_nettype none
module test_tws_ctrl;
   logic CORE_CLK = 0, RST_B = 0, CPU_WR = 0, CPU_RD = 0, CPU_BIT_OP = 0;
   logic [15:0] CPU_ADDR = 16'h0000;
   logic [2:0] CPU_BIT_SEL = 3'h0;
   logic [7:0] CPU_WDATA = 8'h00;
   wire [7:0] CPU_RDATA, P1_OUT, P1_OE, pin, ext, p_rx;
   wire TRANSFER_DONE, p_sck, p_si;
   int error_cnt = 0, num_checks = 0, cyc = 0;
   // driver wins where enabled, far side elsewhere
   assign ext = {5'h16, 1'b1, p_si, p_sck};
   assign pin = (P1_OE & P1_OUT) | (~P1_OE & ext);
   always #2 CORE_CLK = ~CORE_CLK;
   tws_ctrl u_tws_ctrl (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .CPU_ADDR(CPU_ADDR),
      .CPU_WR(CPU_WR), .CPU_RD(CPU_RD), .CPU_BIT_OP(CPU_BIT_OP), .CPU_BIT_SEL(CPU_BIT_SEL),
      .CPU_WDATA(CPU_WDATA), .CPU_RDATA(CPU_RDATA), .P1_IN(pin), .P1_OUT(P1_OUT),
      .P1_OE(P1_OE), .TRANSFER_DONE(TRANSFER_DONE));
   tws_periph u_tws_periph (.sck_pin(pin[0]), .so_pin(pin[2]), .sck_drv(p_sck), .si(p_si),
      .rx(p_rx));
   task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d, input logic bo = 0,
      input logic [2:0] bs = 0);
      @(posedge CORE_CLK);
      #1;
      CPU_ADDR = a;
      CPU_WDATA = d;
      CPU_BIT_OP = bo;
      CPU_BIT_SEL = bs;
      CPU_WR = 1;
      @(posedge CORE_CLK);
      #1 CPU_WR = 0;
   endtask
   task rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge CORE_CLK);
      #1;
      CPU_ADDR = a;
      CPU_RD = 1;
      @(posedge CORE_CLK);
      #1 CPU_RD = 0;
      chk("rdata", exp, CPU_RDATA);
   endtask
   // watch a window of n cycles for the completion pulse
   task wdone(input int n, input logic exp);
      logic got;
      got = 0;
      repeat (n) begin
         @(posedge CORE_CLK);
         #1;
         if (TRANSFER_DONE === 1'b1) got = 1;
      end
      chk("done", {7'h00, exp}, {7'h00, got});
   endtask
   task tally_and_finish();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // cut a hang short
   always @(posedge CORE_CLK) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (20) @(posedge CORE_CLK);
      #1 RST_B = 1;
      rd(16'hFF21, 8'hFF);
      rd(16'hFF80, 8'h00);
      chk("oe", 8'h00, P1_OE);
      rd(16'hFF01, 8'hB5);
      rd(16'h1234, 8'h00);
      wr(16'hFF80, 8'hFF);
      rd(16'hFF80, 8'hD0);
      wr(16'hFF80, 8'h00, 1, 3'h7);
      rd(16'hFF80, 8'h50);
      wr(16'hFF80, 8'h00);
      wr(16'hFF21, 8'h5A);
      repeat (3) @(posedge CORE_CLK);
      chk("oe", 8'hA5, P1_OE);
      wr(16'hFF21, 8'h01, 1, 3'h2);
      rd(16'hFF21, 8'h5E);
      // stop mode: plain port, no transfer
      wr(16'hFF21, 8'hF8);
      wr(16'hFF01, 8'h05);
      wr(16'hFF83, 8'h55);
      wdone(100, 0);
      chk("out", 8'h05, P1_OUT);
      // master transmit and receive, divide by 8
      wr(16'hFF81, 8'hFF);
      rd(16'hFF81, 8'h17);
      wr(16'hFF81, 8'h02);
      wr(16'hFF21, 8'hFA);
      wr(16'hFF01, 8'h01);
      wr(16'hFF80, 8'h40);
      wr(16'hFF80, 8'hC0);
      u_tws_periph.load(8'hA6);
      wr(16'hFF83, 8'h55);
      wdone(100, 1);
      chk("rx", 8'h55, p_rx);
      rd(16'hFF80, 8'hC0);
      rd(16'hFF82, 8'hA6);
      wdone(100, 1);
      // finish a transfer, then disable: the engine reset clears the shifted byte
      u_tws_periph.load(8'h5A);
      wr(16'hFF83, 8'h3C);
      wdone(100, 1);
      chk("rx", 8'h3C, p_rx);
      wr(16'hFF80, 8'h40);
      wr(16'hFF83, 8'h3C);
      wdone(100, 0);
      rd(16'hFF80, 8'h40);
      rd(16'hFF82, 8'h00);
      // slave with the far side clocking
      wr(16'hFF81, 8'h07);
      wr(16'hFF21, 8'hFB);
      wr(16'hFF80, 8'hC0);
      u_tws_periph.load(8'hC3);
      wr(16'hFF83, 8'h96);
      u_tws_periph.run();
      wdone(20, 1);
      chk("rx", 8'h96, p_rx);
      rd(16'hFF82, 8'hC3);
      tally_and_finish();
   end
endmodule
bind tws_ctrl tws_ctrl_chk u_tws_ctrl_chk (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
   .CPU_ADDR(CPU_ADDR), .CPU_WR(CPU_WR), .CPU_RD(CPU_RD), .CPU_RDATA(CPU_RDATA),
   .P1_IN(P1_IN), .P1_OUT(P1_OUT), .P1_OE(P1_OE), .TRANSFER_DONE(TRANSFER_DONE));
`default_nettype wire

//--- dv/tws_ctrl_chk.sv
// Purpose: port-level checks of the serial port control block
// Assumes: one core clock domain, active-low async reset
// Notes: bound to the control top from the bench top file
`timescale 1ns/10ps
`default_nettype none
module tws_ctrl_chk (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_B,
   // processor access
   input wire logic [15:0] CPU_ADDR,
   input wire logic CPU_WR,
   input wire logic CPU_RD,
   input wire logic [7:0] CPU_RDATA,
   // pins and status
   input wire logic [7:0] P1_IN,
   input wire logic [7:0] P1_OUT,
   input wire logic [7:0] P1_OE,
   input wire logic TRANSFER_DONE
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_B);
   // read path: unmapped, fixed fields, holding
   a_unmapped_read: assert property (CPU_RD && !(CPU_ADDR inside {16'hFF21, 16'hFF80,
      16'hFF81, 16'hFF82, 16'hFF83, 16'hFF01}) |=> CPU_RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_mode_fixed_zero: assert property (CPU_RD && CPU_ADDR == 16'hFF80 |=> !(CPU_RDATA & 8'h2E))
      else $error("mode fixed bits not zero");
   a_clk_fixed_zero: assert property (CPU_RD && CPU_ADDR == 16'hFF81 |=> !(CPU_RDATA & 8'hE8))
      else $error("clock select fixed bits not zero");
   a_rdata_hold: assert property (!CPU_RD |=> $stable(CPU_RDATA))
      else $error("read data moved without read");
   // pins other than the serial clock and data-out bits follow only register writes and inputs
   a_dir_stable: assert property (!CPU_WR ##1 !CPU_WR |=> $stable(P1_OE))
      else $error("output enable moved without write");
   a_port_out_stable: assert property (!CPU_WR ##1 !CPU_WR |=> $stable({P1_OUT[7:3], P1_OUT[1]}))
      else $error("port output moved without write");
   a_port_read: assert property ($stable(P1_IN)[*4] ##0 (CPU_RD && CPU_ADDR == 16'hFF01 &&
      P1_OE == 8'h00) |=> CPU_RDATA == $past(P1_IN))
      else $error("port read differs from pins");
   // completion is a lone pulse, followed by at least 8 cycles without it
   a_done_spacing: assert property (TRANSFER_DONE |=> !TRANSFER_DONE [*8])
      else $error("done pulse too long or too close");
endmodule
`default_nettype wire

//--- dv/tws_periph.sv
// Purpose: behavioural far-side peripheral on the three serial lines
// Assumes: clock idles high, data changes on falling and is taken on rising
// Notes: makes the clock only inside a frame when the device is slave
`timescale 1ns/10ps
`default_nettype none
module tws_periph (
   // pin levels seen
   input wire logic sck_pin,
   input wire logic so_pin,
   // lines driven
   output logic sck_drv,
   output logic si,
   // byte taken from the device
   output logic [7:0] rx
);
   logic [7:0] sh = 8'h00;
   logic rose = 1'b0;
   initial sck_drv = 1'b1;
   initial rx = 8'h00;
   assign si = sh[7];
   always @(posedge sck_pin) begin
      rx <= {rx[6:0], so_pin};
      rose <= 1'b1;
   end
   // first bit stands until the first rising edge
   always @(negedge sck_pin) if (rose) sh <= {sh[6:0], 1'b0};
   task load(input logic [7:0] d);
      sh = d;
      rose = 1'b0;
   endtask
   // eight slave clocks, all inside the frame
   task run();
      repeat (8) begin
         #16 sck_drv = 1'b0;
         #16 sck_drv = 1'b1;
      end
   endtask
endmodule
`default_nettype wire

//--- src/tws_ctrl.v
// Purpose: control registers and port-1 pin assignment of a three-wire serial port
// Assumes: one processor access per cycle; read data follows one cycle after the strobe
// Notes: clearing the enable bit holds the shift engine in asynchronous reset
//        unmapped reads return zero, unmapped writes are dropped
//        software must leave clock select alone while the enable bit is set
`timescale 1ns/10ps
`default_nettype none
`include "tws_ctrl_map.vh"

module tws_ctrl (
   // clock and reset
   input wire CORE_CLK,
   input wire RST_B,
   // processor access
   input wire [15:0] CPU_ADDR,
   input wire CPU_WR,
   input wire CPU_RD,
   input wire CPU_BIT_OP,
   input wire [2:0] CPU_BIT_SEL,
   input wire [7:0] CPU_WDATA,
   output reg [7:0] CPU_RDATA,
   // port 1 pins
   input wire [7:0] P1_IN,
   output reg [7:0] P1_OUT,
   output reg [7:0] P1_OE,
   // transfer completion
   output reg TRANSFER_DONE
);

   reg [7:0] port1_direction_r;
   reg [7:0] port1_latch_r;
   reg [7:0] mode_r;
   reg [7:0] clock_sel_r;
   reg [7:0] tx_buffer_r;
   reg [7:0] pin_meta_r;
   reg [7:0] pin_sync_r;
   reg [7:0] rdata_nxt;
   reg [7:0] out_nxt;
   wire hit_dir;
   wire hit_mode;
   wire hit_clk;
   wire hit_shift;
   wire hit_txb;
   wire hit_latch;
   wire enabled;
   wire eng_rst_b;
   wire start;
   wire load_en;
   wire [7:0] txb_nxt;
   wire [7:0] shift_data;
   wire eng_busy;
   wire eng_done;
   wire eng_sck;
   wire eng_so;
   wire is_master;
   wire wr_dir;
   wire wr_mode;
   wire wr_clk;
   wire wr_txb;
   wire wr_latch;
   wire wr_start;
   wire rd_start;

   // merge a byte write or a single-bit write into the old value
   function [7:0] merge_wr;
      input [7:0] old;
      input [7:0] wdata;
      input bit_op;
      input [2:0] sel;
      reg [7:0] one;
      begin
         one = 8'h01 << sel;
         if (bit_op) begin
            merge_wr = wdata[0] ? (old | one) : (old & ~one);
         end else begin
            merge_wr = wdata;
         end
      end
   endfunction

   // input pins read the pin level, output pins read back the latch
   function [7:0] port_view;
      input [7:0] pins;
      input [7:0] latch;
      input [7:0] dir;
      begin
         port_view = (pins & dir) | (latch & ~dir);
      end
   endfunction

   // address decode
   assign hit_dir = (CPU_ADDR == `TWS_ADDR_PORT1_DIR);
   assign hit_mode = (CPU_ADDR == `TWS_ADDR_MODE_CTRL);
   assign hit_clk = (CPU_ADDR == `TWS_ADDR_CLOCK_SEL);
   assign hit_shift = (CPU_ADDR == `TWS_ADDR_SHIFT);
   assign hit_txb = (CPU_ADDR == `TWS_ADDR_TX_BUFFER);
   assign hit_latch = (CPU_ADDR == `TWS_ADDR_PORT1_LATCH);

   // enable gates the engine and its reset
   assign enabled = mode_r[`TWS_MODE_ENABLE];
   assign eng_rst_b = RST_B & enabled;
   assign is_master = (clock_sel_r[`TWS_CLK_SRC_HI:0] != `TWS_CLK_SRC_SLAVE);

   // write strobes per register, one access per cycle
   assign wr_dir = CPU_WR && hit_dir;
   assign wr_mode = CPU_WR && hit_mode;
   assign wr_clk = CPU_WR && hit_clk;
   assign wr_txb = CPU_WR && hit_txb;
   assign wr_latch = CPU_WR && hit_latch;

   // transfer start from buffer write or shift read
   assign load_en = wr_txb;
   assign txb_nxt = merge_wr(tx_buffer_r, CPU_WDATA, CPU_BIT_OP, CPU_BIT_SEL);
   assign wr_start = wr_txb;
   assign rd_start = CPU_RD && hit_shift;
   assign start = enabled && !eng_busy && (wr_start || rd_start);

   // two-stage synchroniser on every port pin
   always @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         pin_meta_r <= 8'h00;
         pin_sync_r <= 8'h00;
      end else begin
         pin_meta_r <= P1_IN;
         pin_sync_r <= pin_meta_r;
      end
   end

   // shift engine, reset while disabled
   // engine reset clears
   tws_shift u_shift (
      .clk(CORE_CLK),
      .rst_b(eng_rst_b),
      .start(start),
      .load_en(load_en),
      .load_data(txb_nxt),
      .tx_en(mode_r[`TWS_MODE_TX_RX]),
      .lsb_first(mode_r[`TWS_MODE_BIT_ORDER]),
      .clk_src(clock_sel_r[`TWS_CLK_SRC_HI:0]),
      .clk_pol(clock_sel_r[`TWS_CLK_POLARITY]),
      .sck_sync(pin_sync_r[`TWS_PIN_SCK]),
      .si_sync(pin_sync_r[`TWS_PIN_SI]),
      .sck_out(eng_sck),
      .so_r(eng_so),
      .busy_r(eng_busy),
      .done_r(eng_done),
      .shift_r(shift_data)
   );

   always @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         port1_direction_r <= `TWS_RST_PORT1_DIR;
      end else if (wr_dir) begin
         port1_direction_r <= merge_wr(port1_direction_r, CPU_WDATA, CPU_BIT_OP,
                                       CPU_BIT_SEL);
      end
   end

   always @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         mode_r <= `TWS_RST_MODE_CTRL;
      end else if (wr_mode) begin
         mode_r <= merge_wr(mode_r, CPU_WDATA, CPU_BIT_OP, CPU_BIT_SEL) & `TWS_MODE_WR_MASK;
      end
   end

   // clock select, unused bits kept at zero
   always @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         clock_sel_r <= `TWS_RST_CLOCK_SEL;
      end else if (wr_clk) begin
         clock_sel_r <= merge_wr(clock_sel_r, CPU_WDATA, CPU_BIT_OP, CPU_BIT_SEL) &
                        `TWS_CLK_WR_MASK;
      end
   end

   // transmit buffer keeps the last written byte
   always @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         tx_buffer_r <= `TWS_RST_DATA;
      end else if (wr_txb) begin
         tx_buffer_r <= txb_nxt;
      end
   end

   // port-1 output latch
   always @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         port1_latch_r <= `TWS_RST_DATA;
      end else if (wr_latch) begin
         port1_latch_r <= merge_wr(port1_latch_r, CPU_WDATA, CPU_BIT_OP, CPU_BIT_SEL);
      end
   end

   // read mux, unmapped addresses read zero
   always @* begin
      rdata_nxt = 8'h00;
      case (CPU_ADDR)
         `TWS_ADDR_PORT1_DIR: begin
            rdata_nxt = port1_direction_r;
         end
         `TWS_ADDR_MODE_CTRL: begin
            rdata_nxt = mode_r & `TWS_MODE_WR_MASK;
            rdata_nxt[`TWS_MODE_BUSY] = eng_busy;
         end
         `TWS_ADDR_CLOCK_SEL: begin
            rdata_nxt = clock_sel_r;
         end
         `TWS_ADDR_SHIFT: begin
            rdata_nxt = shift_data;
         end
         `TWS_ADDR_TX_BUFFER: begin
            rdata_nxt = tx_buffer_r;
         end
         `TWS_ADDR_PORT1_LATCH: begin
            rdata_nxt = port_view(pin_sync_r, port1_latch_r, port1_direction_r);
         end
         default: begin
            rdata_nxt = 8'h00;
         end
      endcase
   end

   // pin output selection
   always @* begin
      out_nxt = port1_latch_r;
      if (enabled) begin
         if (is_master) begin
            out_nxt[`TWS_PIN_SCK] = eng_sck & port1_latch_r[`TWS_PIN_SCK];
         end
         if (mode_r[`TWS_MODE_TX_RX]) begin
            out_nxt[`TWS_PIN_SO] = eng_so | port1_latch_r[`TWS_PIN_SO];
         end
      end
   end

   // read data, held until the next read
   always @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         CPU_RDATA <= 8'h00;
      end else if (CPU_RD) begin
         CPU_RDATA <= rdata_nxt;
      end
   end

   // pin levels and output enables
   always @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         P1_OUT <= 8'h00;
         P1_OE <= 8'h00;
      end else begin
         P1_OUT <= out_nxt;
         P1_OE <= ~port1_direction_r;
      end
   end

   always @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         TRANSFER_DONE <= 1'b0;
      end else begin
         TRANSFER_DONE <= eng_done;
      end
   end

endmodule
`default_nettype wire

//--- src/tws_ctrl_map.vh
// Purpose: addresses, field positions, reset values and masks of the serial port block
// Assumes: byte-wide processor data, 16-bit processor address
// Notes: included by the control top and the shift engine
`ifndef TWS_CTRL_MAP_VH
`define TWS_CTRL_MAP_VH

// register addresses
`define TWS_ADDR_PORT1_DIR    16'hFF21
`define TWS_ADDR_MODE_CTRL    16'hFF80
`define TWS_ADDR_CLOCK_SEL    16'hFF81
`define TWS_ADDR_SHIFT        16'hFF82
`define TWS_ADDR_TX_BUFFER    16'hFF83
`define TWS_ADDR_PORT1_LATCH  16'hFF01

// reset values
`define TWS_RST_PORT1_DIR     8'hFF
`define TWS_RST_MODE_CTRL     8'h00
`define TWS_RST_CLOCK_SEL     8'h00
`define TWS_RST_DATA          8'h00

// mode register fields
`define TWS_MODE_ENABLE       7
`define TWS_MODE_TX_RX        6
`define TWS_MODE_BIT_ORDER    4
`define TWS_MODE_BUSY         0
`define TWS_MODE_WR_MASK      8'hD0

// clock select fields
`define TWS_CLK_POLARITY      4
`define TWS_CLK_SRC_HI        2
`define TWS_CLK_WR_MASK       8'h17
`define TWS_CLK_SRC_SLAVE     3'h7

// serial pin positions on port 1
`define TWS_PIN_SCK           0
`define TWS_PIN_SI            1
`define TWS_PIN_SO            2

// transfer length
`define TWS_LAST_BIT          4'h7

`endif

//--- src/tws_shift.v
// Purpose: 8-bit shift engine with master clock divider and slave clock edge finder
// Assumes: sck_sync and si_sync already pass two flip-flops in the core clock domain
// Notes: rst_b here combines the system reset with the enable bit
`timescale 1ns/10ps
`default_nettype none
`include "tws_ctrl_map.vh"

module tws_shift (
   // clock and combined reset
   input wire clk,
   input wire rst_b,
   // control
   input wire start,
   input wire load_en,
   input wire [7:0] load_data,
   input wire tx_en,
   input wire lsb_first,
   input wire [2:0] clk_src,
   input wire clk_pol,
   // serial lines
   input wire sck_sync,
   input wire si_sync,
   output wire sck_out,
   output reg so_r,
   // status
   output reg busy_r,
   output reg done_r,
   output reg [7:0] shift_r
);

   reg [6:0] div_r;
   reg ph_r;
   reg prev_ph_r;
   reg [3:0] cnt_r;
   wire slave;
   wire ph_now;
   wire tick;
   wire fall;
   wire rise;
   wire [7:0] start_data;

   // half-period limit of the master clock: 2^sel core cycles
   function [6:0] half_lim;
      input [2:0] sel;
      begin
         half_lim = (7'h01 << sel) - 7'h01;
      end
   endfunction

   // bit that goes out next for the chosen order
   function out_bit;
      input [7:0] data;
      input lsb;
      begin
         out_bit = lsb ? data[0] : data[7];
      end
   endfunction

   // internal phase is high when idle, but stays low after a transfer with clock select 0; falling drives, rising samples
   assign slave = (clk_src == `TWS_CLK_SRC_SLAVE);
   assign ph_now = slave ? (sck_sync ^ clk_pol) : ph_r;
   assign tick = busy_r && !slave && (div_r == half_lim(clk_src));
   assign fall = prev_ph_r && !ph_now;
   assign rise = !prev_ph_r && ph_now;
   assign sck_out = ph_r ^ clk_pol;
   assign start_data = load_en ? load_data : shift_r;

   // shift engine
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_r <= 7'h00;
         ph_r <= 1'b1;
         prev_ph_r <= 1'b1;
         cnt_r <= 4'h0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         shift_r <= `TWS_RST_DATA;
         so_r <= 1'b0;
      end else begin
         prev_ph_r <= ph_now;
         done_r <= 1'b0;
         if (start && !busy_r) begin
            busy_r <= 1'b1;
            cnt_r <= 4'h0;
            div_r <= 7'h00;
            ph_r <= 1'b1;
            shift_r <= start_data;
            so_r <= tx_en & out_bit(start_data, lsb_first);
         end else if (busy_r) begin
            if (tick) begin
               div_r <= 7'h00;
               ph_r <= ~ph_r;
            end else if (!slave) begin
               div_r <= div_r + 7'h01;
            end
            if (fall) begin
               so_r <= tx_en & out_bit(shift_r, lsb_first);
            end
            if (rise) begin
               shift_r <= lsb_first ? {si_sync, shift_r[7:1]} : {shift_r[6:0], si_sync};
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r == `TWS_LAST_BIT) begin
                  busy_r <= 1'b0;
                  done_r <= 1'b1;
               end
            end
         end
      end
   end

endmodule
`default_nettype wire
